// ### arwc_codec.sv
/*
 * radio tuning and integrity word codec: builds words from registers,
 * decodes received words by label, compares protection levels to limits.
 * assumes words, strobes and protection levels come from same-clock logic.
 */
`default_nettype none
module arwc_codec #(
    parameter int unsigned TACAN1_PERIOD = arwc_pkg::TACAN1_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire arwc_pkg::arwc_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    output logic [31:0] tx_word,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [31:0] rx_word,
    input wire logic rx_valid,
    input wire logic [15:0] hpl_m,
    input wire logic [15:0] vpl_m,
    output logic horiz_unavail,
    output logic vert_unavail,
    output logic rx_parity_err,
    output arwc_pkg::arwc_rx_flags_t rx_flags
);
    logic periodic_en_q;
    logic [15:0] nav_q;
    logic [14:0] xpdr_q;
    logic [14:0] tacan1_q;
    logic [13:0] tacan2_q;
    logic [17:0] hal_q;
    logic [9:0] val_q;
    logic sw_pend_q;
    arwc_pkg::arwc_kind_t sw_kind_q;
    logic per_pend_q;
    logic [31:0] per_cnt_q;
    arwc_pkg::arwc_tx_state_t tx_state_q;
    logic [31:0] tx_word_q;
    logic [30:0] body;
    logic body_odd;
    logic rx_odd;
    logic load;
    arwc_pkg::arwc_kind_t load_kind;
    logic per_wrap;
    logic rx_good;
    logic rx_bad;
    logic perr_q;
    logic [31:0] rx_last_q;
    logic [16:0] eff_hal_q;
    logic [9:0] rx_val_q;
    arwc_pkg::arwc_rx_flags_t rx_flags_q;
    logic horiz_unavail_q;
    logic vert_unavail_q;
    logic [31:0] rdata_q;
    logic [19:0] hpl_dm;
    logic wr_hit_status;

    // software register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodic_en_q <= 1'b0;
            nav_q <= 16'h0000;
            xpdr_q <= 15'h0000;
            tacan1_q <= 15'h0000;
            tacan2_q <= 14'h0000;
            hal_q <= 18'h00000;
            val_q <= 10'h000;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                arwc_pkg::REG_CTRL: periodic_en_q <= bus_req.wdata[0];
                arwc_pkg::REG_NAV: nav_q <= bus_req.wdata[15:0];
                arwc_pkg::REG_XPDR: xpdr_q <= bus_req.wdata[14:0];
                arwc_pkg::REG_TACAN1: tacan1_q <= bus_req.wdata[14:0];
                arwc_pkg::REG_TACAN2: tacan2_q <= bus_req.wdata[13:0];
                arwc_pkg::REG_HAL: hal_q <= bus_req.wdata[17:0];
                arwc_pkg::REG_VAL: val_q <= bus_req.wdata[9:0];
                default: ;
            endcase
        end
    end

    // software send request, one pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_pend_q <= 1'b0;
            sw_kind_q <= arwc_pkg::KIND_NAV;
        end else if (bus_req.wr && bus_req.addr == arwc_pkg::REG_TX_SEND) begin
            sw_pend_q <= 1'b1;
            sw_kind_q <= arwc_pkg::arwc_kind_t'(bus_req.wdata[2:0]);
        end else if (load && sw_pend_q) begin
            sw_pend_q <= 1'b0;
        end
    end

    // first tacan word repeat timer
    assign per_wrap = periodic_en_q && (per_cnt_q == 32'(TACAN1_PERIOD - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_q <= 32'h00000000;
        end else if (!periodic_en_q || per_wrap) begin
            per_cnt_q <= 32'h00000000;
        end else begin
            per_cnt_q <= per_cnt_q + 32'h00000001;
        end
    end

    // periodic pending: set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            per_pend_q <= 1'b0;
        end else begin
            per_pend_q <= per_wrap | (per_pend_q & ~(load && !sw_pend_q));
        end
    end

    assign load = (tx_state_q == arwc_pkg::TX_IDLE) && (sw_pend_q || per_pend_q);
    assign load_kind = sw_pend_q ? sw_kind_q : arwc_pkg::KIND_TACAN1;

    // word body without parity
    always_comb begin
        body = 31'h00000000;
        case (load_kind)
            arwc_pkg::KIND_NAV: begin
                body[7:0] = arwc_pkg::LBL_NAV_TUNE;
                body[arwc_pkg::POS_NAV_ILS] = nav_q[0];
                body[arwc_pkg::POS_NAV_FREQ_LO +: arwc_pkg::FREQ_W] = nav_q[15:1];
                body[arwc_pkg::POS_SSM_LO +: 2] = arwc_pkg::SSM_FAIL;
            end
            arwc_pkg::KIND_XPDR: begin
                body[7:0] = arwc_pkg::LBL_XPDR;
                body[arwc_pkg::POS_XPDR_CODE_LO +: arwc_pkg::XCODE_W] = xpdr_q[11:0];
                body[arwc_pkg::POS_XPDR_ALT_OFF] = xpdr_q[12];
                body[arwc_pkg::POS_XPDR_IDENT] = xpdr_q[13];
                body[arwc_pkg::POS_XPDR_SRC] = xpdr_q[14];
            end
            arwc_pkg::KIND_TACAN1: begin
                body[7:0] = arwc_pkg::LBL_TACAN1;
                body[arwc_pkg::POS_TAC_DIST] = tacan1_q[0];
                body[arwc_pkg::POS_TAC_BRG] = tacan1_q[1];
                body[arwc_pkg::POS_TAC_SEL] = tacan1_q[2];
                body[arwc_pkg::POS_TAC_CHAN_LO +: arwc_pkg::CHAN_W] = tacan1_q[10:3];
                body[arwc_pkg::POS_TAC_MODE_LO +: 2] = tacan1_q[12:11];
                body[arwc_pkg::POS_SSM_LO +: 2] = tacan1_q[14:13];
            end
            arwc_pkg::KIND_TACAN2: begin
                body[7:0] = arwc_pkg::LBL_TACAN2;
                body[arwc_pkg::POS_TAC_NAV_LO +: 2] = tacan2_q[1:0];
                body[arwc_pkg::POS_TAC_MODE_LO +: 2] = tacan2_q[3:2];
                body[arwc_pkg::POS_SSM_LO +: 2] = tacan2_q[5:4];
                body[arwc_pkg::POS_TAC_CHAN_LO +: arwc_pkg::CHAN_W] = tacan2_q[13:6];
            end
            arwc_pkg::KIND_HAL: begin
                body[7:0] = arwc_pkg::LBL_HAL;
                body[arwc_pkg::POS_HAL_LO +: arwc_pkg::HAL_W] = hal_q[12:0];
                body[arwc_pkg::POS_HAL_PAD_LO +: 2] = arwc_pkg::SSM_NCD;
                body[arwc_pkg::POS_PHASE_LO +: arwc_pkg::PHASE_W] = hal_q[15:13];
                if ((&hal_q[12:0]) && hal_q[15:13] == arwc_pkg::PHASE_NONE) begin
                    body[arwc_pkg::POS_SSM_LO +: 2] = arwc_pkg::SSM_NCD;
                end else begin
                    body[arwc_pkg::POS_SSM_LO +: 2] = hal_q[17:16];
                end
            end
            arwc_pkg::KIND_VAL: begin
                body[7:0] = arwc_pkg::LBL_VAL;
                body[arwc_pkg::POS_VAL_LO +: arwc_pkg::VAL_W] = val_q[7:0];
                body[arwc_pkg::POS_VAL_PAD_LO +: arwc_pkg::VAL_PAD_W] = 10'h000;
                body[arwc_pkg::POS_SSM_LO +: 2] = val_q[9:8];
            end
            default: body = 31'h00000000;
        endcase
    end

    arwc_odd_parity u_tx_par (
        .word({1'b0, body}),
        .ones_odd(body_odd)
    );

    arwc_odd_parity u_rx_par (
        .word(rx_word),
        .ones_odd(rx_odd)
    );

    // transmit holding word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_q <= arwc_pkg::TX_IDLE;
            tx_word_q <= 32'h00000000;
        end else begin
            case (tx_state_q)
                arwc_pkg::TX_IDLE: begin
                    if (load) begin
                        tx_word_q <= {~body_odd, body};
                        tx_state_q <= arwc_pkg::TX_FULL;
                    end
                end
                arwc_pkg::TX_FULL: begin
                    if (tx_ready) begin
                        tx_state_q <= arwc_pkg::TX_IDLE;
                    end
                end
                default: tx_state_q <= arwc_pkg::TX_IDLE;
            endcase
        end
    end

    assign tx_word = tx_word_q;
    assign tx_valid = (tx_state_q == arwc_pkg::TX_FULL);

    // receive path
    assign rx_good = rx_valid && rx_odd;
    assign rx_bad = rx_valid && !rx_odd;
    assign wr_hit_status = bus_req.wr && bus_req.addr == arwc_pkg::REG_STATUS;

    // sticky parity error, set wins over write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_q <= 1'b0;
        end else begin
            perr_q <= rx_bad | (perr_q & ~(wr_hit_status & bus_req.wdata[arwc_pkg::ST_PERR]));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_last_q <= 32'h00000000;
        end else if (rx_good) begin
            rx_last_q <= rx_word;
        end
    end

    // field decoding by label
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_flags_q <= '0;
            rx_val_q <= 10'h000;
        end else if (rx_good) begin
            case (rx_word[7:0])
                arwc_pkg::LBL_NAV_TUNE: rx_flags_q.ils_sel <= rx_word[arwc_pkg::POS_NAV_ILS];
                arwc_pkg::LBL_XPDR: begin
                    rx_flags_q.alt_off <= rx_word[arwc_pkg::POS_XPDR_ALT_OFF];
                    rx_flags_q.ident <= rx_word[arwc_pkg::POS_XPDR_IDENT];
                    rx_flags_q.alt_src2 <= rx_word[arwc_pkg::POS_XPDR_SRC];
                end
                arwc_pkg::LBL_TACAN1: begin
                    rx_flags_q.distance_memory_flag <= rx_word[arwc_pkg::POS_TAC_DIST];
                    rx_flags_q.bearing_memory_flag <= rx_word[arwc_pkg::POS_TAC_BRG];
                    rx_flags_q.tac_sel <= rx_word[arwc_pkg::POS_TAC_SEL];
                end
                arwc_pkg::LBL_TACAN2: begin
                    rx_flags_q.nav_sys <= rx_word[arwc_pkg::POS_TAC_NAV_LO +: 2];
                    rx_flags_q.tacan_mode <= rx_word[arwc_pkg::POS_TAC_MODE_LO +: 2];
                    rx_flags_q.tacan_ssm <= rx_word[arwc_pkg::POS_SSM_LO +: 2];
                end
                arwc_pkg::LBL_VAL: begin
                    rx_val_q <= {rx_word[arwc_pkg::POS_SSM_LO +: 2],
                                 rx_word[arwc_pkg::POS_VAL_LO +: arwc_pkg::VAL_W]};
                end
                default: ;
            endcase
        end
    end

    // effective horizontal limit in decimetres, pad bits ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eff_hal_q <= 17'h00000;
        end else if (rx_good && rx_word[7:0] == arwc_pkg::LBL_HAL) begin
            if (&rx_word[27:arwc_pkg::POS_HAL_ONES_LO]) begin
                if (rx_word[arwc_pkg::POS_PHASE_LO +: arwc_pkg::PHASE_W] == arwc_pkg::PHASE_NPA) begin
                    eff_hal_q <= arwc_pkg::DEF_HAL_NPA_DM;
                end
            end else begin
                eff_hal_q <= 17'(17'(rx_word[arwc_pkg::POS_HAL_LO +: arwc_pkg::HAL_W]) *
                                 17'(arwc_pkg::DM_PER_M));
            end
        end
    end

    assign hpl_dm = 20'(20'(hpl_m) * 20'(arwc_pkg::DM_PER_M));

    // integrity availability
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            horiz_unavail_q <= 1'b0;
            vert_unavail_q <= 1'b0;
        end else begin
            horiz_unavail_q <= hpl_dm > 20'(eff_hal_q);
            vert_unavail_q <= vpl_m > 16'(rx_val_q[7:0]);
        end
    end

    assign horiz_unavail = horiz_unavail_q;
    assign vert_unavail = vert_unavail_q;
    assign rx_parity_err = perr_q;
    assign rx_flags = rx_flags_q;

    // register read, data one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                arwc_pkg::REG_CTRL: rdata_q <= {31'h00000000, periodic_en_q};
                arwc_pkg::REG_TX_SEND: rdata_q <= {30'h00000000, per_pend_q, sw_pend_q};
                arwc_pkg::REG_NAV: rdata_q <= {16'h0000, nav_q};
                arwc_pkg::REG_XPDR: rdata_q <= {17'h00000, xpdr_q};
                arwc_pkg::REG_TACAN1: rdata_q <= {17'h00000, tacan1_q};
                arwc_pkg::REG_TACAN2: rdata_q <= {18'h00000, tacan2_q};
                arwc_pkg::REG_HAL: rdata_q <= {14'h0000, hal_q};
                arwc_pkg::REG_VAL: rdata_q <= {22'h000000, val_q};
                arwc_pkg::REG_STATUS: rdata_q <= {29'h00000000, perr_q, vert_unavail_q,
                                                  horiz_unavail_q};
                arwc_pkg::REG_RX_HAL: rdata_q <= {15'h0000, eff_hal_q};
                arwc_pkg::REG_RX_LAST: rdata_q <= rx_last_q;
                arwc_pkg::REG_RX_VAL: rdata_q <= {22'h000000, rx_val_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end else begin
            rdata_q <= 32'h00000000;
        end
    end

    assign bus_rdata = rdata_q;

    // checks
    property p_tx_parity;
        @(posedge clk) disable iff (!rst_n) tx_valid |-> (^tx_word);
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("tx word parity even");

    property p_nav_ils;
        @(posedge clk) disable iff (!rst_n)
            (load && load_kind == arwc_pkg::KIND_NAV) |=>
            (tx_word[arwc_pkg::POS_NAV_ILS] == $past(nav_q[0]));
    endproperty
    a_nav_ils: assert property (p_nav_ils) else $error("tuning word type bit wrong");

    property p_hal_ncd;
        @(posedge clk) disable iff (!rst_n)
            (tx_valid && tx_word[7:0] == arwc_pkg::LBL_HAL && (&tx_word[27:15]) &&
             tx_word[12:10] == arwc_pkg::PHASE_NONE) |-> (tx_word[30:29] == arwc_pkg::SSM_NCD);
    endproperty
    a_hal_ncd: assert property (p_hal_ncd) else $error("all ones limit lacks no data");

    property p_hal_pad;
        @(posedge clk) disable iff (!rst_n)
            (tx_valid && tx_word[7:0] == arwc_pkg::LBL_HAL) |-> (tx_word[14:13] == arwc_pkg::SSM_NCD);
    endproperty
    a_hal_pad: assert property (p_hal_pad) else $error("horizontal pad bits wrong");

    property p_val_pad;
        @(posedge clk) disable iff (!rst_n)
            (tx_valid && tx_word[7:0] == arwc_pkg::LBL_VAL) |-> (tx_word[19:10] == 10'h000);
    endproperty
    a_val_pad: assert property (p_val_pad) else $error("vertical pad bits not zero");

    property p_rx_perr;
        @(posedge clk) disable iff (!rst_n) (rx_valid && !(^rx_word)) |=> rx_parity_err;
    endproperty
    a_rx_perr: assert property (p_rx_perr) else $error("bad parity word not flagged");

    property p_rx_drop;
        @(posedge clk) disable iff (!rst_n) (rx_valid && !(^rx_word)) |=> $stable(rx_last_q);
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("bad parity word was kept");

    property p_subst;
        @(posedge clk) disable iff (!rst_n)
            (rx_valid && (^rx_word) && rx_word[7:0] == arwc_pkg::LBL_HAL && (&rx_word[27:17]) &&
             rx_word[12:10] == arwc_pkg::PHASE_NPA) |=> (eff_hal_q == arwc_pkg::DEF_HAL_NPA_DM);
    endproperty
    a_subst: assert property (p_subst) else $error("phase default limit not taken");

    property p_horiz;
        @(posedge clk) disable iff (!rst_n)
            ($stable(hpl_m) && $stable(eff_hal_q)) |-> (horiz_unavail == (hpl_dm > 20'(eff_hal_q)));
    endproperty
    a_horiz: assert property (p_horiz) else $error("horizontal availability wrong");

    property p_vert;
        @(posedge clk) disable iff (!rst_n)
            ($stable(vpl_m) && $stable(rx_val_q)) |->
            (vert_unavail == (vpl_m > 16'(rx_val_q[7:0])));
    endproperty
    a_vert: assert property (p_vert) else $error("vertical availability wrong");

    property p_period;
        @(posedge clk) disable iff (!rst_n) per_cnt_q < 32'(TACAN1_PERIOD);
    endproperty
    a_period: assert property (p_period) else $error("repeat counter overran");
endmodule // arwc_codec
`default_nettype wire

// ### arwc_odd_parity.sv
/*
 * odd-parity reduction over one 32-bit word.
 * assumes a combinational path is acceptable in the caller.
 */
`default_nettype none
module arwc_odd_parity (
    input wire logic [31:0] word,
    output logic ones_odd
);
    // high when the word holds an odd number of ones
    assign ones_odd = ^word;
endmodule // arwc_odd_parity
`default_nettype wire

// ### arwc_pkg.sv
/*
 * constants, types and field positions for the radio word codec.
 * assumes one 100 MHz clock; word bit n of the line format is index n-1 here.
 */
`default_nettype none
package arwc_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TACAN1_RATE_HZ = 5;
    localparam int unsigned TACAN1_PERIOD_CYC = CLK_HZ / TACAN1_RATE_HZ;

    localparam logic [7:0] LBL_NAV_TUNE = 8'h1C;
    localparam logic [7:0] LBL_XPDR = 8'h19;
    localparam logic [7:0] LBL_TACAN1 = 8'h66;
    localparam logic [7:0] LBL_TACAN2 = 8'h67;
    localparam logic [7:0] LBL_HAL = 8'h54;
    localparam logic [7:0] LBL_VAL = 8'h57;

    localparam int POS_PARITY = 31;
    localparam int POS_SSM_LO = 29;
    localparam int POS_HAL_LO = 15;
    localparam int POS_HAL_PAD_LO = 13;
    localparam int POS_HAL_ONES_LO = 17;
    localparam int POS_PHASE_LO = 10;
    localparam int POS_VAL_LO = 20;
    localparam int POS_VAL_PAD_LO = 10;
    localparam int POS_NAV_ILS = 13;
    localparam int POS_NAV_FREQ_LO = 14;
    localparam int POS_XPDR_ALT_OFF = 10;
    localparam int POS_XPDR_IDENT = 12;
    localparam int POS_XPDR_SRC = 13;
    localparam int POS_XPDR_CODE_LO = 17;
    localparam int POS_TAC_DIST = 10;
    localparam int POS_TAC_BRG = 11;
    localparam int POS_TAC_SEL = 13;
    localparam int POS_TAC_CHAN_LO = 16;
    localparam int POS_TAC_MODE_LO = 26;
    localparam int POS_TAC_NAV_LO = 14;

    localparam int HAL_W = 13;
    localparam int VAL_W = 8;
    localparam int VAL_PAD_W = 10;
    localparam int PHASE_W = 3;
    localparam int FREQ_W = 15;
    localparam int XCODE_W = 12;
    localparam int CHAN_W = 8;
    localparam int PL_W = 16;
    localparam int DM_W = 17;
    localparam int CMP_W = 20;

    // status codes as {bit31, bit30}
    localparam logic [1:0] SSM_FAIL = 2'h0;
    localparam logic [1:0] SSM_NCD = 2'h1;
    localparam logic [1:0] SSM_TEST = 2'h2;
    localparam logic [1:0] SSM_NORMAL = 2'h3;
    localparam logic [1:0] TSSM_VALID = 2'h0;
    localparam logic [1:0] TSSM_TEST = 2'h1;
    localparam logic [1:0] TSSM_NCD = 2'h2;
    localparam logic [1:0] TSSM_UNUSED = 2'h3;
    // system as {bit16, bit15}, mode as {bit28, bit27}
    localparam logic [1:0] NAV_TACAN = 2'h0;
    localparam logic [1:0] NAV_MLS_W = 2'h1;
    localparam logic [1:0] NAV_UNUSED = 2'h2;
    localparam logic [1:0] NAV_MLS_Z = 2'h3;
    localparam logic [1:0] MODE_REC = 2'h0;
    localparam logic [1:0] MODE_TR = 2'h1;
    localparam logic [1:0] MODE_AA_REC = 2'h2;
    localparam logic [1:0] MODE_AA_TR = 2'h3;

    localparam logic [2:0] PHASE_NONE = 3'h0;
    localparam logic [2:0] PHASE_NPA = 3'h4;
    localparam logic [16:0] DEF_HAL_NPA_DM = 17'h015B4;
    localparam logic [3:0] DM_PER_M = 4'hA;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX_SEND = 8'h04;
    localparam logic [7:0] REG_NAV = 8'h08;
    localparam logic [7:0] REG_XPDR = 8'h0C;
    localparam logic [7:0] REG_TACAN1 = 8'h10;
    localparam logic [7:0] REG_TACAN2 = 8'h14;
    localparam logic [7:0] REG_HAL = 8'h18;
    localparam logic [7:0] REG_VAL = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_RX_HAL = 8'h24;
    localparam logic [7:0] REG_RX_LAST = 8'h28;
    localparam logic [7:0] REG_RX_VAL = 8'h2C;
    localparam int ST_PERR = 2;

    typedef enum logic [2:0] {
        KIND_NAV = 3'h0,
        KIND_XPDR = 3'h1,
        KIND_TACAN1 = 3'h2,
        KIND_TACAN2 = 3'h3,
        KIND_HAL = 3'h4,
        KIND_VAL = 3'h5
    } arwc_kind_t;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_FULL = 1'b1
    } arwc_tx_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } arwc_bus_req_t;

    typedef struct packed {
        logic ils_sel;
        logic alt_off;
        logic ident;
        logic alt_src2;
        logic distance_memory_flag;
        logic bearing_memory_flag;
        logic tac_sel;
        logic [1:0] nav_sys;
        logic [1:0] tacan_mode;
        logic [1:0] tacan_ssm;
    } arwc_rx_flags_t;
endpackage : arwc_pkg
`default_nettype wire

// ### arwc_radio_model.sv
/*
 * far-side radio unit model: takes sent words, sends received words.
 * assumes it shares the codec clock.
 */
`default_nettype none
module arwc_radio_model (
    input wire logic clk,
    input wire logic [31:0] tx_word,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [31:0] rx_word,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt = 2'h0;
    initial begin
        tx_ready = 1'b0;
        rx_word = 32'h0;
        rx_valid = 1'b0;
    end
    // takes words promptly or after a stall
    always @(posedge clk) begin
        cnt <= cnt + 2'h1;
        tx_ready <= tx_valid && cnt[0];
    end
    task automatic send(input logic [31:0] w);
        @(posedge clk);
        rx_word <= w;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_word <= ~w;
    endtask
endmodule // arwc_radio_model
`default_nettype wire

// ### avionics_radio_word_codec_test.sv
/*
 * self-checking bench for the radio word codec.
 * assumes the package, codec and radio model are compiled first.
 */
`default_nettype none
module avionics_radio_word_codec_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n;
    arwc_pkg::arwc_bus_req_t bus_req;
    logic [31:0] bus_rdata, tx_word, rx_word, w;
    logic tx_valid, tx_ready, rx_valid;
    logic rd_q = 1'b0;
    logic [15:0] hpl_m, vpl_m;
    logic [30:0] b;
    logic horiz_unavail, vert_unavail, rx_parity_err;
    arwc_pkg::arwc_rx_flags_t rx_flags;
    time t0;
    localparam int PER = 50;
    logic [31:0] exp_q[$];
    int fail_count = 0, checked = 0, seed = 32'hdc52;
    always #5 clk = ~clk;
    arwc_codec #(.TACAN1_PERIOD(PER)) i_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_word(rx_word), .rx_valid(rx_valid), .hpl_m(hpl_m), .vpl_m(vpl_m),
        .horiz_unavail(horiz_unavail), .vert_unavail(vert_unavail),
        .rx_parity_err(rx_parity_err), .rx_flags(rx_flags));
    arwc_radio_model i_radio (.clk(clk), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid));
    function automatic logic [31:0] par(input logic [30:0] v);
        return {~^v, v};
    endfunction
    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic go(input logic wr, rd, input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{wr, rd, a, d};
        @(posedge clk);
    endtask
    task automatic send_wait(input logic [2:0] kind, input logic [31:0] want);
        exp_q.push_back(want);
        go(1'b1, 1'b0, arwc_pkg::REG_TX_SEND, {29'h0, kind});
        go(1'b0, 1'b0, 8'h0, 32'h0);
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge clk);
    endtask
    task automatic snd(input logic [7:0] a, input logic [31:0] d, input logic [2:0] k,
        input logic [30:0] v);
        go(1'b1, 1'b0, a, d);
        send_wait(k, par(v));
        i_radio.send(par(v));
    endtask
    always @(posedge clk) begin
        rd_q <= bus_req.rd;
        if (rd_q) chk(bus_rdata, exp_q.pop_front());
        if (tx_valid && tx_ready) chk(tx_word, exp_q.pop_front());
    end
    initial begin
        bus_req = '0;
        rst_n = 1'b0;
        hpl_m = 16'h0;
        vpl_m = 16'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        go(1'b1, 1'b0, arwc_pkg::REG_HAL, 32'h0003_1FFF);
        send_wait(3'h4, par({2'h1, 1'b0, 13'h1FFF, 2'h1, 3'h0, 10'h054}));
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            snd(arwc_pkg::REG_HAL, {14'h0, w[17:16], 3'h4, 1'b0, w[11:0]}, 3'h4,
                {w[17:16], 2'h0, w[11:0], 2'h1, 3'h4, 10'h054});
            snd(arwc_pkg::REG_VAL, {22'h0, w[9:0]}, 3'h5,
                {w[9:8], 1'b0, w[7:0], 20'h57});
            snd(arwc_pkg::REG_NAV, {16'h0, w[15:0]}, 3'h0,
                {2'h0, w[15:1], w[0], 5'h0, 8'h1C});
            snd(arwc_pkg::REG_XPDR, {17'h0, w[14:0]}, 3'h1,
                {2'h0, w[11:0], 3'h0, w[14:13], 1'b0, w[12], 2'h0, 8'h19});
            snd(arwc_pkg::REG_TACAN2, {18'h0, w[13:0]}, 3'h3,
                {w[5:4], 1'b0, w[3:2], 2'h0, w[13:6], w[1:0], 6'h0, 8'h67});
        end
        go(1'b1, 1'b0, arwc_pkg::REG_TACAN1, {17'h0, w[14:0]});
        b = {w[14:13], 1'b0, w[12:11], 2'h0, w[10:3], 2'h0, w[2], 1'b0, w[1:0], 2'h0, 8'h66};
        exp_q.push_back(par(b));
        exp_q.push_back(par(b));
        go(1'b1, 1'b0, arwc_pkg::REG_CTRL, 32'h1);
        go(1'b0, 1'b0, 8'h0, 32'h0);
        do @(posedge clk); while (!(tx_valid && tx_ready));
        t0 = $time;
        do @(posedge clk); while (!(tx_valid && tx_ready));
        chk(32'(($time - t0) / 10), PER);
        go(1'b1, 1'b0, arwc_pkg::REG_CTRL, 32'h0);
        go(1'b0, 1'b0, 8'h0, 32'h0);
        i_radio.send(par(b));
        @(posedge clk);
        chk(rx_flags, {w[0], w[12], w[13], w[14], w[0], w[1], w[2],
            w[1:0], w[3:2], w[5:4]});
        hpl_m <= 16'd101;
        w = par({2'h3, 1'b0, 13'd100, 2'h1, 3'h0, 10'h054});
        i_radio.send(w);
        exp_q.push_back(32'd1000);
        go(1'b0, 1'b1, arwc_pkg::REG_RX_HAL, 32'h0);
        exp_q.push_back(32'h1);
        go(1'b0, 1'b1, arwc_pkg::REG_STATUS, 32'h0);
        go(1'b0, 1'b0, 8'h0, 32'h0);
        i_radio.send(w ^ 32'h8000_0000);
        exp_q.push_back(32'h5);
        go(1'b0, 1'b1, arwc_pkg::REG_STATUS, 32'h0);
        go(1'b0, 1'b0, 8'h0, 32'h0);
        i_radio.send(par({2'h3, 1'b0, 13'h1FFF, 2'h1, 3'h4, 10'h054}));
        exp_q.push_back(32'd5556);
        go(1'b0, 1'b1, arwc_pkg::REG_RX_HAL, 32'h0);
        go(1'b0, 1'b0, 8'h0, 32'h0);
        vpl_m <= 16'd50;
        w = par({2'h3, 1'b0, 8'd49, 20'h57});
        i_radio.send(w);
        exp_q.push_back(32'h331);
        go(1'b0, 1'b1, arwc_pkg::REG_RX_VAL, 32'h0);
        exp_q.push_back(w);
        go(1'b0, 1'b1, arwc_pkg::REG_RX_LAST, 32'h0);
        exp_q.push_back(32'h6);
        go(1'b0, 1'b1, arwc_pkg::REG_STATUS, 32'h0);
        go(1'b1, 1'b0, arwc_pkg::REG_STATUS, 32'h4);
        exp_q.push_back(32'h2);
        go(1'b0, 1'b1, arwc_pkg::REG_STATUS, 32'h0);
        go(1'b0, 1'b0, 8'h0, 32'h0);
        repeat (2) @(posedge clk);
        chk({rx_parity_err, vert_unavail, horiz_unavail}, 32'h2);
        chk(exp_q.size(), 32'h0);
        report_and_stop;
    end
    initial begin
        #20us;
        fail_count++;
        report_and_stop;
    end
endmodule // avionics_radio_word_codec_test
`default_nettype wire
